// [common/seq_ctrl_pkg.sv]
// Contract
// - Select1 reg at 0x27, window 00, disarmed write
// - Select2 reg visible at window 01, disarmed write
// - Select3 reg visible at window 10, disarmed write
// - Flag reg read at window 11, writes ignored
// - Four-bit code; unmentioned channels cause nothing
// - State1 codes 0000 to 0011 transitions
// - State1 codes 0100 to 0111 transitions
// - State1 codes 1001, 1101; others reserved
// - Final wins, then lowest channel number
// - State2 codes 0000 to 0011 transitions
// - State2 codes 0100 to 0111 transitions
// - State2 codes 1100, 1111; others reserved
// - State3 codes 0000 to 0011 transitions
// - State3 codes 0100 to 0111 transitions
// - State3 codes 1010, 1101, 1110; rest reserved
// - Three sticky per-channel flags until next arm
// - Flags cleared only by arming, not software
// - Flags set independently; repeats change nothing
// - Comparator matches only with enable bit set
package seq_ctrl_pkg;

  // ==========================================================
  // Register map
  // ==========================================================
  localparam logic [7:0] SEL_OFFSET   = 8'h27; // Shared offset
  localparam logic [7:0] ARM_OFFSET   = 8'h20; // Arm / window control
  localparam logic [7:0] CMP_OFFSET   = 8'h28; // Comparator control
  localparam int         ARM_BIT      = 7;     // Arm bit position
  localparam int         WIN_LSB      = 0;     // Window select low bit
  localparam int         ENABLE_BIT   = 0;     // Comparator enable bit
  localparam logic [1:0] WIN_SEL1     = 2'h0;  // State1 select visible
  localparam logic [1:0] WIN_SEL2     = 2'h1;  // State2 select visible
  localparam logic [1:0] WIN_SEL3     = 2'h2;  // State3 select visible
  localparam logic [1:0] WIN_FLAGS    = 2'h3;  // Flag register visible
  localparam logic [3:0] CODE_RESET   = 4'h0;  // Select code after reset

  // ==========================================================
  // Sequencer states
  // ==========================================================
  typedef enum logic [2:0]
  {
    ST_IDLE,
    ST_ONE,
    ST_TWO,
    ST_THREE,
    ST_FINAL
  } seq_state_t;

endpackage : seq_ctrl_pkg

// [hdl/seq_ctrl.sv]
// Strobed register access was left to the implementer.
`timescale 1ns/100ps
// Debug state sequencer next-state selection with match flags.
module seq_ctrl
(
  input  wire logic       clk_i,        // 20 MHz bus clock
  input  wire logic       rst_i,        // Async reset, active high
  input  wire logic [7:0] addr_i,       // Register byte address
  input  wire logic [7:0] wdata_i,      // Write data
  input  wire logic       wr_i,         // Write strobe
  input  wire logic       rd_i,         // Read strobe
  input  wire logic [2:0] cmp_match_i,  // Raw comparator hits
  output logic      [7:0] rdata_o,      // Read data, cycle after rd_i
  output logic            armed_o,      // Session active
  output logic      [2:0] seq_state_o,  // Current sequencer state
  output logic            final_o       // Final state reached pulse
);

  // ==========================================================
  // State record
  // ==========================================================
  typedef struct packed
  {
    logic                     armed;     // Session in progress
    logic [1:0]               window;    // Window select
    logic [3:0]               code1;     // State1 next-state code
    logic [3:0]               code2;     // State2 next-state code
    logic [3:0]               code3;     // State3 next-state code
    logic [2:0]               cmp_en;    // Per-comparator enables
    logic [2:0]               flags;     // Sticky match flags
    seq_ctrl_pkg::seq_state_t state;     // Sequencer state
    logic                     fin;       // Final pulse
    logic [7:0]               rdata;     // Read data register
  } regs_t;

  regs_t q_r;    // Registered state
  regs_t q_nxt;  // Next state

  // Target of one decoded channel: none, final, or a state
  typedef enum logic [2:0]
  {
    TG_NONE,
    TG_S1,
    TG_S2,
    TG_S3,
    TG_FIN
  } target_t;

  // ==========================================================
  // Next-state tables
  // ==========================================================
  // Map of (state, code, channel) to target; reserved codes and
  // unmentioned channels give no transition.
  function automatic target_t lookup
  (
    input logic [1:0] st,
    input logic [3:0] code,
    input logic [1:0] ch
  );
    target_t t;
    t = TG_NONE;
    case (st)
      2'h1: // State1
        case (code)
          4'h0: t = TG_FIN;
          4'h1: t = (ch == 2'h1) ? TG_S3 : TG_NONE;
          4'h2: t = (ch == 2'h2) ? TG_S2 : TG_NONE;
          4'h3: t = (ch == 2'h1) ? TG_S2 : TG_NONE;
          4'h4: t = (ch == 2'h0) ? TG_S2 :
                    (ch == 2'h1) ? TG_S3 : TG_NONE;
          4'h5: t = (ch == 2'h1) ? TG_S3 :
                    (ch == 2'h0) ? TG_FIN : TG_NONE;
          4'h6: t = (ch == 2'h0) ? TG_S2 :
                    (ch == 2'h2) ? TG_S3 : TG_NONE;
          4'h7: t = (ch != 2'h2) ? TG_S2 : TG_NONE;
          4'h9: t = (ch == 2'h0) ? TG_S3 : TG_NONE;
          4'hD: t = (ch == 2'h1) ? TG_S2 : TG_FIN;
          default: t = TG_NONE;
        endcase
      2'h2: // State2
        case (code)
          4'h0: t = (ch == 2'h0) ? TG_S1 :
                    (ch == 2'h2) ? TG_S3 : TG_NONE;
          4'h1: t = (ch == 2'h1) ? TG_S3 : TG_NONE;
          4'h2: t = (ch == 2'h2) ? TG_S3 : TG_NONE;
          4'h3: t = (ch == 2'h1) ? TG_S3 :
                    (ch == 2'h0) ? TG_FIN : TG_NONE;
          4'h4: t = (ch == 2'h1) ? TG_S1 :
                    (ch == 2'h2) ? TG_S3 : TG_NONE;
          4'h5: t = (ch == 2'h2) ? TG_FIN : TG_NONE;
          4'h6: t = (ch == 2'h2) ? TG_S1 :
                    (ch == 2'h0) ? TG_FIN : TG_NONE;
          4'h7: t = (ch != 2'h2) ? TG_FIN : TG_NONE;
          4'hC: t = (ch == 2'h2) ? TG_S3 : TG_FIN;
          4'hF: t = (ch == 2'h2) ? TG_S1 : TG_FIN;
          default: t = TG_NONE;
        endcase
      2'h3: // State3
        case (code)
          4'h0: t = (ch == 2'h0) ? TG_S1 : TG_NONE;
          4'h1: t = (ch == 2'h2) ? TG_S2 :
                    (ch == 2'h1) ? TG_FIN : TG_NONE;
          4'h2: t = (ch == 2'h0) ? TG_FIN :
                    (ch == 2'h1) ? TG_S1 : TG_NONE;
          4'h3: t = (ch == 2'h1) ? TG_FIN :
                    (ch == 2'h2) ? TG_S1 : TG_NONE;
          4'h4: t = (ch == 2'h1) ? TG_S2 : TG_NONE;
          4'h5: t = (ch == 2'h1) ? TG_FIN : TG_NONE;
          4'h6: t = (ch == 2'h2) ? TG_S2 :
                    (ch == 2'h0) ? TG_FIN : TG_NONE;
          4'h7: t = (ch == 2'h0) ? TG_FIN : TG_NONE;
          4'hA: t = (ch == 2'h0) ? TG_FIN : TG_S1;
          4'hD: t = (ch == 2'h0) ? TG_S1 : TG_FIN;
          4'hE: t = (ch == 2'h0) ? TG_S2 :
                    (ch == 2'h2) ? TG_FIN : TG_NONE;
          default: t = TG_NONE;
        endcase
      default: t = TG_NONE;
    endcase
    return t;
  endfunction : lookup

  // ==========================================================
  // Match qualification
  // ==========================================================
  // Comparator hits count only while enabled; software must set
  // the enables before expecting transitions.
  logic [2:0] match;     // Qualified match channels
  logic       arm_wr;    // Write to arm/window control
  logic       arm_set;   // Arming event this cycle

  always_comb
  begin
    match  = cmp_match_i & q_r.cmp_en;
    arm_wr = wr_i && (addr_i == seq_ctrl_pkg::ARM_OFFSET);
    arm_set = arm_wr && wdata_i[seq_ctrl_pkg::ARM_BIT];
  end

  // ==========================================================
  // Transition choice
  // ==========================================================
  // Final wins over any other target; otherwise lowest channel.
  target_t    chosen;  // Winning target
  logic [1:0] st_idx;  // State as table index
  target_t    tg0;     // Channel 0 target
  target_t    tg1;     // Channel 1 target
  target_t    tg2;     // Channel 2 target
  logic [3:0] cur_code;// Code for current state

  always_comb
  begin
    case (q_r.state)
      seq_ctrl_pkg::ST_ONE:   st_idx = 2'h1;
      seq_ctrl_pkg::ST_TWO:   st_idx = 2'h2;
      seq_ctrl_pkg::ST_THREE: st_idx = 2'h3;
      default:                st_idx = 2'h0;
    endcase
    case (st_idx)
      2'h1:    cur_code = q_r.code1;
      2'h2:    cur_code = q_r.code2;
      default: cur_code = q_r.code3;
    endcase
    tg0 = match[0] ? lookup(st_idx, cur_code, 2'h0) : TG_NONE;
    tg1 = match[1] ? lookup(st_idx, cur_code, 2'h1) : TG_NONE;
    tg2 = match[2] ? lookup(st_idx, cur_code, 2'h2) : TG_NONE;
    // Final first, then channel 0, 1, 2
    if (tg0 == TG_FIN || tg1 == TG_FIN || tg2 == TG_FIN)
      chosen = TG_FIN;
    else if (tg0 != TG_NONE)
      chosen = tg0;
    else if (tg1 != TG_NONE)
      chosen = tg1;
    else
      chosen = tg2;
  end

  // ==========================================================
  // Next-state logic
  // ==========================================================
  always_comb
  begin
    q_nxt     = q_r;
    q_nxt.fin = 1'b0;
    q_nxt.rdata = 8'h00;
    // Register reads; unmapped addresses read zero
    if (rd_i)
    begin
      if (addr_i == seq_ctrl_pkg::SEL_OFFSET)
        case (q_r.window)
          seq_ctrl_pkg::WIN_SEL1: q_nxt.rdata = {4'h0, q_r.code1};
          seq_ctrl_pkg::WIN_SEL2: q_nxt.rdata = {4'h0, q_r.code2};
          seq_ctrl_pkg::WIN_SEL3: q_nxt.rdata = {4'h0, q_r.code3};
          default:                q_nxt.rdata = {5'h00, q_r.flags};
        endcase
      else if (addr_i == seq_ctrl_pkg::ARM_OFFSET)
        q_nxt.rdata = {q_r.armed, 5'h00, q_r.window};
      else if (addr_i == seq_ctrl_pkg::CMP_OFFSET)
        q_nxt.rdata = {5'h00, q_r.cmp_en};
    end
    // Select writes only while disarmed; flag writes dropped
    if (wr_i && addr_i == seq_ctrl_pkg::SEL_OFFSET && !q_r.armed)
      case (q_r.window)
        seq_ctrl_pkg::WIN_SEL1: q_nxt.code1 = wdata_i[3:0];
        seq_ctrl_pkg::WIN_SEL2: q_nxt.code2 = wdata_i[3:0];
        seq_ctrl_pkg::WIN_SEL3: q_nxt.code3 = wdata_i[3:0];
        default:                ;
      endcase
    if (wr_i && addr_i == seq_ctrl_pkg::CMP_OFFSET)
      q_nxt.cmp_en = wdata_i[2:0];
    // Sequencer run
    if (q_r.armed)
    begin
      // Sticky, independent flags
      q_nxt.flags = q_r.flags | match;
      case (chosen)
        TG_S1:  q_nxt.state = seq_ctrl_pkg::ST_ONE;
        TG_S2:  q_nxt.state = seq_ctrl_pkg::ST_TWO;
        TG_S3:  q_nxt.state = seq_ctrl_pkg::ST_THREE;
        TG_FIN:
        begin
          q_nxt.state = seq_ctrl_pkg::ST_FINAL;
          q_nxt.fin   = 1'b1;
          q_nxt.armed = 1'b0;  // Session ends at final state
        end
        default: ;
      endcase
    end
    // Control write: window, arm; arming clears flags
    if (arm_wr)
    begin
      q_nxt.window = wdata_i[seq_ctrl_pkg::WIN_LSB +: 2];
      if (arm_set && !q_r.armed)
      begin
        q_nxt.armed = 1'b1;
        q_nxt.flags = 3'h0;
        q_nxt.state = seq_ctrl_pkg::ST_ONE;
      end
      else if (!arm_set)
      begin
        q_nxt.armed = 1'b0;  // Software disarm
        q_nxt.state = seq_ctrl_pkg::ST_IDLE;
      end
    end
  end

  // ==========================================================
  // State register
  // ==========================================================
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      q_r        <= '0;
      q_r.state  <= seq_ctrl_pkg::ST_IDLE;
      q_r.code1  <= seq_ctrl_pkg::CODE_RESET;
      q_r.code2  <= seq_ctrl_pkg::CODE_RESET;
      q_r.code3  <= seq_ctrl_pkg::CODE_RESET;
    end
    else
      q_r <= q_nxt;
  end

  // Outputs straight from flops
  assign rdata_o     = q_r.rdata;
  assign armed_o     = q_r.armed;
  assign seq_state_o = q_r.state;
  assign final_o     = q_r.fin;

  // ==========================================================
  // Checks
  // ==========================================================
  // Select codes stay frozen for the whole session, all three windows
  sel_write_lock_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (wr_i && addr_i == seq_ctrl_pkg::SEL_OFFSET && armed_o)
      |=> q_r.code1 == $past(q_r.code1) && q_r.code2 == $past(q_r.code2)
          && q_r.code3 == $past(q_r.code3))
    else $error("select code changed while armed");

  sel2_read_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (rd_i && addr_i == seq_ctrl_pkg::SEL_OFFSET &&
     q_r.window == seq_ctrl_pkg::WIN_SEL2)
      |=> rdata_o == {4'h0, $past(q_r.code2)})
    else $error("state2 select read wrong");

  sel3_read_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (rd_i && addr_i == seq_ctrl_pkg::SEL_OFFSET &&
     q_r.window == seq_ctrl_pkg::WIN_SEL3)
      |=> rdata_o == {4'h0, $past(q_r.code3)})
    else $error("state3 select read wrong");

  flag_read_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (rd_i && addr_i == seq_ctrl_pkg::SEL_OFFSET &&
     q_r.window == seq_ctrl_pkg::WIN_FLAGS)
      |=> rdata_o == {5'h00, $past(q_r.flags)})
    else $error("flag register read wrong");

  // A control write in the same cycle may disarm and win, so skip it
  final_prio_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (armed_o && !arm_wr &&
     (tg0 == TG_FIN || tg1 == TG_FIN || tg2 == TG_FIN))
      |=> final_o && seq_state_o == seq_ctrl_pkg::ST_FINAL)
    else $error("final transition not taken");

  flag_sticky_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (armed_o && match != 3'h0) |=> (q_r.flags & $past(match)) == $past(match))
    else $error("match flag not set");

  flag_clear_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (q_r.flags != 3'h0 && !arm_set) |=> (q_r.flags & $past(q_r.flags))
      == $past(q_r.flags))
    else $error("flag cleared without arming");

  disabled_cmp_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (armed_o && !arm_wr && (cmp_match_i & q_r.cmp_en) == 3'h0)
      |=> seq_state_o == $past(seq_state_o))
    else $error("disabled comparator moved sequencer");

  // Window reads and the write-ignored flag window
  sel1_read_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (rd_i && addr_i == seq_ctrl_pkg::SEL_OFFSET &&
     q_r.window == seq_ctrl_pkg::WIN_SEL1)
      |=> rdata_o == {4'h0, $past(q_r.code1)})
    else $error("state1 select read wrong");

  flag_write_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (wr_i && addr_i == seq_ctrl_pkg::SEL_OFFSET && !armed_o &&
     q_r.window == seq_ctrl_pkg::WIN_FLAGS)
      |=> q_r.flags == $past(q_r.flags) && q_r.code1 == $past(q_r.code1)
          && q_r.code2 == $past(q_r.code2)
          && q_r.code3 == $past(q_r.code3))
    else $error("write at flag window changed a register");

  // A match that the current code does not mention leaves the state
  no_move_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (armed_o && !arm_wr && match != 3'h0 && chosen == TG_NONE)
      |=> seq_state_o == $past(seq_state_o))
    else $error("unmentioned match moved sequencer");

  // Reserved codes behave as if no channel were mentioned
  reserved1_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (armed_o && !arm_wr && seq_state_o == seq_ctrl_pkg::ST_ONE &&
     q_r.code1 == 4'h8)
      |=> seq_state_o == seq_ctrl_pkg::ST_ONE)
    else $error("reserved state1 code moved sequencer");

  reserved2_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (armed_o && !arm_wr && seq_state_o == seq_ctrl_pkg::ST_TWO &&
     q_r.code2 == 4'h9)
      |=> seq_state_o == seq_ctrl_pkg::ST_TWO)
    else $error("reserved state2 code moved sequencer");

  reserved3_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (armed_o && !arm_wr && seq_state_o == seq_ctrl_pkg::ST_THREE &&
     q_r.code3 == 4'hF)
      |=> seq_state_o == seq_ctrl_pkg::ST_THREE)
    else $error("reserved state3 code moved sequencer");

  // Arming starts a fresh session in State1 with clear flags
  arm_start_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (arm_set && !armed_o)
      |=> armed_o && q_r.flags == 3'h0 &&
          seq_state_o == seq_ctrl_pkg::ST_ONE)
    else $error("arming did not clear flags or start State1");

  // Outside a session nothing but arming touches the flags
  flag_hold_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (!armed_o && !arm_set) |=> q_r.flags == $past(q_r.flags))
    else $error("flags changed outside a session");

endmodule : seq_ctrl

// [testbench/match_source.sv]
`timescale 1ns/100ps
// ==========================================================
// Comparator match channels seen from the sequencer
// ==========================================================
module match_source
(
  input  wire logic       clk_i,   // Bus clock
  input  wire logic       rst_i,   // Async reset, active high
  input  wire logic [2:0] fire_i,  // Hit request, bit n = channel n
  output logic      [2:0] match_o  // Registered one-cycle hit pulses
);
  // Each comparator hit lasts one bus cycle; registering it keeps
  // the request clear of the edge where the sequencer samples it
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      match_o <= 3'h0;            // Quiet while in reset
    else
      match_o <= fire_i;          // Channel n is comparator n+1
  end
endmodule : match_source

// [testbench/test_debug_state_sequencer_control.sv]
`timescale 1ns/100ps
// ==========================================================
// Bench for the sequencer next-state and match flag logic
// ==========================================================
module test_debug_state_sequencer_control;
  logic       clk_i;        // 20 MHz bus clock
  logic       rst_i;        // Async reset
  logic [7:0] addr_i;       // Register address
  logic [7:0] wdata_i;      // Write data
  logic       wr_i;         // Write strobe
  logic       rd_i;         // Read strobe
  logic [2:0] fire;         // Hit requests to the comparator model
  logic [2:0] cmp_match_i;  // Hits from the comparator model
  logic [7:0] rdata_o;      // Read data
  logic       armed_o;      // Session active
  logic [2:0] seq_state_o;  // Sequencer state
  logic       final_o;      // Final state pulse
  int         mismatches;   // Failed comparisons
  int         n_tests;      // All comparisons
  int         cycles;       // Watchdog count
  // Vectors: start state, code, hit mask, expected state (4 = Final)
  localparam logic [15:0] vec_tbl [39] = '{
    16'h1044, 16'h1111, 16'h1123, 16'h1242, 16'h1322, 16'h1432,
    16'h1534, 16'h1643, 16'h1722, 16'h1913, 16'h1D34, 16'h1D22,
    16'h2051, 16'h2123, 16'h2243, 16'h2334, 16'h2461, 16'h2544,
    16'h2654, 16'h2724, 16'h2C43, 16'h2F54, 16'h2F41, 16'h3011,
    16'h3164, 16'h3234, 16'h3341, 16'h3422, 16'h3513, 16'h3642,
    16'h3714, 16'h3A61, 16'h3A14, 16'h3D11, 16'h3D44, 16'h3E54,
    16'h1871, 16'h2972, 16'h3F73};

  // ==========================================================
  // Design and far side
  // ==========================================================
  seq_ctrl i_seq_ctrl (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .cmp_match_i(cmp_match_i), .rdata_o(rdata_o), .armed_o(armed_o),
    .seq_state_o(seq_state_o), .final_o(final_o));
  match_source i_match_source (.clk_i(clk_i), .rst_i(rst_i),
    .fire_i(fire), .match_o(cmp_match_i));

  // Free-running clock, 50 ns period
  always #25 clk_i = ~clk_i;

  // Watchdog; a full run needs well under 3000 cycles
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      mismatches++;
      close_out();
    end
  end

  // ==========================================================
  // Bus, stimulus and comparison tasks
  // ==========================================================
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One-cycle write strobe
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i    <= 1'b0;
  endtask : wr_reg

  // Read strobe; data stand only in the following cycle
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    #1;
    chk(rdata_o, exp);
  endtask : rd_chk

  // Open a window, then write the shared offset
  task automatic set_code(input logic [7:0] w, input logic [7:0] c);
    wr_reg(seq_ctrl_pkg::ARM_OFFSET, w);
    wr_reg(seq_ctrl_pkg::SEL_OFFSET, c);
  endtask : set_code

  // One hit through the model; returns once the state has settled
  task automatic pulse(input logic [2:0] m);
    @(posedge clk_i);
    fire <= m;
    @(posedge clk_i);
    fire <= 3'h0;
    @(posedge clk_i);
    #1;
  endtask : pulse

  // Reach the start state, hit once, then read back the flags
  task automatic run_vec(input logic [15:0] v);
    logic [3:0] s, c, m, e, pre;
    s   = v[15:12];
    c   = v[11:8];
    m   = v[7:4];
    e   = v[3:0];
    pre = (s == 4'h2) ? 4'h4 : ((s == 4'h3) ? 4'h2 : 4'h0);
    wr_reg(seq_ctrl_pkg::ARM_OFFSET, 8'h00);
    if (s == 4'h1)
      set_code(8'h00, {4'h0, c});
    else
    begin
      // State1 routes channel2 to State2, channel1 to State3
      set_code(8'h00, (s == 4'h2) ? 8'h02 : 8'h01);
      set_code({4'h0, s - 4'h1}, {4'h0, c});
    end
    wr_reg(seq_ctrl_pkg::ARM_OFFSET, 8'h80);
    #1;
    chk({7'h0, armed_o}, 8'h01);
    if (pre != 4'h0)
    begin
      pulse(pre[2:0]);
      chk({5'h0, seq_state_o}, {4'h0, s});
    end
    pulse(m[2:0]);
    chk({5'h0, seq_state_o}, {4'h0, e});
    chk({7'h0, final_o}, {7'h0, e == 4'h4});
    chk({7'h0, armed_o}, {7'h0, e != 4'h4});
    wr_reg(seq_ctrl_pkg::ARM_OFFSET, 8'h03);
    wr_reg(seq_ctrl_pkg::SEL_OFFSET, 8'h00);  // Flags survive
    rd_chk(seq_ctrl_pkg::SEL_OFFSET, {4'h0, pre | m});
  endtask : run_vec

  // Verdict and end of run
  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : close_out

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial
  begin
    clk_i = 1'b0;
    rst_i = 1'b1;
    addr_i = 8'h00;
    wdata_i = 8'h00;
    wr_i = 1'b0;
    rd_i = 1'b0;
    fire = 3'h0;
    mismatches = 0;
    n_tests = 0;
    cycles = 0;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    // Register windows, disarmed and armed
    rd_chk(seq_ctrl_pkg::SEL_OFFSET, 8'h00);
    wr_reg(seq_ctrl_pkg::CMP_OFFSET, 8'h07); // Enables first
    set_code(8'h00, 8'h05);
    set_code(8'h01, 8'h0A);
    set_code(8'h02, 8'h0C);
    set_code(8'h03, 8'h07);
    rd_chk(seq_ctrl_pkg::SEL_OFFSET, 8'h00);
    wr_reg(seq_ctrl_pkg::ARM_OFFSET, 8'h00);
    rd_chk(seq_ctrl_pkg::SEL_OFFSET, 8'h05);
    wr_reg(seq_ctrl_pkg::ARM_OFFSET, 8'h01);
    rd_chk(seq_ctrl_pkg::SEL_OFFSET, 8'h0A);
    set_code(8'h82, 8'h0F);
    rd_chk(seq_ctrl_pkg::SEL_OFFSET, 8'h0C);
    set_code(8'h81, 8'h0F);
    rd_chk(seq_ctrl_pkg::SEL_OFFSET, 8'h0A);
    set_code(8'h80, 8'h0F);
    wr_reg(seq_ctrl_pkg::ARM_OFFSET, 8'h00);
    rd_chk(seq_ctrl_pkg::SEL_OFFSET, 8'h05);
    rd_chk(8'h10, 8'h00);
    // Disabled channel neither moves the state nor sets a flag
    wr_reg(seq_ctrl_pkg::CMP_OFFSET, 8'h03);
    set_code(8'h00, 8'h00);
    wr_reg(seq_ctrl_pkg::ARM_OFFSET, 8'h80);
    pulse(3'h4);
    chk({5'h0, seq_state_o}, {5'h0, seq_ctrl_pkg::ST_ONE});
    wr_reg(seq_ctrl_pkg::ARM_OFFSET, 8'h03);
    rd_chk(seq_ctrl_pkg::SEL_OFFSET, 8'h00);
    wr_reg(seq_ctrl_pkg::CMP_OFFSET, 8'h07);
    // Every documented code of every state, with simultaneous hits
    for (int i = 0; i < 39; i++)
      run_vec(vec_tbl[i]);
    close_out();
  end
endmodule : test_debug_state_sequencer_control
